//--- sfp_pkg.sv
/*
  Shared constants for the serial flash page-program command block:
  opcodes, status bit positions, timing figures and state encodings.
  Assumes a 250 MHz system clock and SPI mode 0 on the link.
*/
package sfp_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 4;
  localparam int PAGE_PROG_TIME_NS_DF = 500000;  // default page program time

  // ---------------------------------------------------------------
  // page geometry
  // ---------------------------------------------------------------
  localparam logic [8:0] PAGE_BYTES = 9'h100;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_WR_EN        = 8'h06;
  localparam logic [7:0] OPC_WR_DIS       = 8'h04;
  localparam logic [7:0] OPC_RD_ST1       = 8'h05;
  localparam logic [7:0] OPC_RD_ST2       = 8'h07;
  localparam logic [7:0] OPC_CLR_STAT     = 8'h30;
  localparam logic [7:0] OPC_PAGE_PROG    = 8'h02;
  localparam logic [7:0] OPC_PAGE_PROG_4B = 8'h12;
  localparam logic [7:0] OPC_DDR_RD       = 8'hED;
  localparam logic [7:0] OPC_DDR_RD_4B    = 8'hEE;

  // ---------------------------------------------------------------
  // status register bit positions
  // ---------------------------------------------------------------
  localparam int ST1_WIP_BIT  = 0;
  localparam int ST1_WEL_BIT  = 1;
  localparam int ST2_PERR_BIT = 5;

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [9:0] {
    S_IDLE  = 10'h001,
    S_OPC   = 10'h002,
    S_ADDR  = 10'h004,
    S_DATA  = 10'h008,
    S_STAT  = 10'h010,
    S_RADDR = 10'h020,
    S_RMODE = 10'h040,
    S_RDUM  = 10'h080,
    S_RDATA = 10'h100,
    S_IGN   = 10'h200
  } sfp_cmd_st_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_XFER = 3'h2,
    P_WAIT = 3'h4
  } sfp_prog_st_t;

endpackage

//--- sfp_sync.sv
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes each bit is a slow level relative to the system clock.
*/
`timescale 1ns/1ps
module sfp_sync #(
  parameter int         W       = 6,
  parameter logic [5:0] RST_VAL = 6'h20
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfp_sync_st_t;

  sfp_sync_st_t r;
  sfp_sync_st_t n;

  // first stage is read only by the second stage
  always_comb begin
    n    = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  // register stage, idle pin levels at reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r.s1 <= W'(RST_VAL);
      r.s2 <= W'(RST_VAL);
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;

endmodule // sfp_sync

//--- sfp_skid_fifo.sv
/*
  Small valid/ready buffer between the page buffer drain and the array.
  Assumes the consumer may stall for any number of cycles.
*/
`timescale 1ns/1ps
module sfp_skid_fifo #(
  parameter int W     = 40,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             count;
  } sfp_fifo_st_t;

  sfp_fifo_st_t r;
  sfp_fifo_st_t n;
  logic         push;
  logic         pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (r.count != '0);
  assign out_data_o  = r.mem[r.rptr];

  // pointer and count update
  always_comb begin
    n    = r;
    push = in_valid_i & in_ready_o;
    pop  = out_valid_o & out_ready_i;
    if (push) begin
      n.mem[r.wptr] = in_data_i;
      n.wptr        = (r.wptr == AW'(DEPTH-1)) ? '0 : AW'(r.wptr + 1'b1);
    end
    if (pop) begin
      n.rptr = (r.rptr == AW'(DEPTH-1)) ? '0 : AW'(r.rptr + 1'b1);
    end
    n.count = (AW+1)'(r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  a_fifo_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    (r.count == (AW+1)'(DEPTH)) && !out_ready_i |=> (r.count == (AW+1)'(DEPTH)))
    else $error("fifo lost an entry while stalled");

endmodule // sfp_skid_fifo

//--- sfp_flash_cmd.sv
/*
  Command side of a serial NOR flash: write enable, page load and program,
  status reads and the DDR quad read with its learning preamble.
  Assumes SPI mode 0 pins sampled by a much faster system clock, and an
  array port that stores old_byte AND prog data, reading combinationally.
*/
// Overview of operation
// - preamble byte is driven identically on all four IO lines during DDR read
// - device drives preamble the four clock cycles before first read data
// - four-line mode sends DDR read opcode four bits per rising edge
// - continuous DDR read mode, dummy, data are the same in four-line mode
// - DDR read address MSB is 23, or 31 when wide bit or EEh
// - program data staged in page buffer, at most 256 bytes per operation
// - pages aligned to 256, anything from one bit to a page programmable
// - single-byte program accepted at any array address
// - programming only clears bits, never sets them back to one
// - page program needs write enable latch, set by write enable command
// - 02h takes 3 or 4 address bytes per wide bit, 12h always 4
// - chip select must rise on a byte boundary or program is discarded
// - valid chip select rise starts a self-timed program of fixed time
// - in-progress flag is status1 bit 0, cleared when programming completes
// - program error flag status2 bit 5 set when a program targets a protected area
// - four-line mode shifts opcode, address and data on all four lines
`timescale 1ns/1ps
module sfp_flash_cmd
  import sfp_pkg::*;
#(
  parameter int PAGE_PROG_TIME_NS = PAGE_PROG_TIME_NS_DF
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // spi pins
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_in_i,
  output logic      [3:0]  io_out_o,
  output logic      [3:0]  io_oe_o,
  // configuration
  input  wire logic        addr4_mode_i,
  input  wire logic        four_line_mode_i,
  input  wire logic        learning_enable_i,
  input  wire logic [7:0]  learning_pattern_i,
  input  wire logic [3:0]  dummy_cycles_i,
  input  wire logic        region_protected_i,
  // status
  output logic             op_in_progress_o,
  output logic             write_enable_latch_o,
  output logic             program_error_o,
  // array program port
  output logic             prog_valid_o,
  output logic      [31:0] prog_addr_o,
  output logic      [7:0]  prog_data_o,
  input  wire logic        prog_ready_i,
  // array read port
  output logic      [31:0] rd_addr_o,
  input  wire logic [7:0]  rd_data_i
);

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  // least time, so round up
  localparam int PROG_CYCLES = (PAGE_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TW          = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    sfp_cmd_st_t         cmd_st;
    sfp_prog_st_t        pst;
    logic                sck_q;
    logic                cs_q;
    logic [7:0]          shreg;
    logic [3:0]          bitcnt;
    logic [3:0]          cnt;
    logic [31:0]         addr;
    logic                wide;
    logic [255:0][7:0]   pbuf;
    logic [7:0]          pstart;
    logic [8:0]          pcount;
    logic [8:0]          xfer;
    logic [TW-1:0]       timer;
    logic                write_enable_latch;
    logic                op_in_progress;
    logic                perr;
    logic                stat2_sel;
    logic                cont;
    logic                mode_ok;
    logic [4:0]          beat;
    logic                pend;
    logic                nib;
    logic [31:0]         rd_addr;
    logic [3:0]          io_out;
    logic [3:0]          io_oe;
  } sfp_cmd_reg_t;

  sfp_cmd_reg_t r;
  sfp_cmd_reg_t n;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pins_s;
  logic       cs_s;
  logic       sck_s;
  logic [3:0] io_s;

  sfp_sync #(
    .W       (6),
    .RST_VAL (6'h20)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({cs_n_i, sck_i, io_in_i}),
    .q_o    (pins_s)
  );

  assign cs_s  = pins_s[5];
  assign sck_s = pins_s[4];
  assign io_s  = pins_s[3:0];

  // ---------------------------------------------------------------
  // program drain buffer
  // ---------------------------------------------------------------
  logic        push;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [39:0] fifo_out_data;
  logic [7:0]  rd_idx;
  logic [7:0]  wr_idx;

  // the array may stall; the drain engine waits on in_ready
  sfp_skid_fifo #(
    .W     (40),
    .DEPTH (2)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_data_i   ({r.addr[31:8], rd_idx, r.pbuf[rd_idx]}),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (prog_ready_i)
  );

  // ---------------------------------------------------------------
  // command decoder and program engine
  // ---------------------------------------------------------------
  logic       rise;
  logic       fall;
  logic       edge_any;
  logic       commit;
  logic [7:0] sdr_byte;
  logic [3:0] bits_nx;
  logic [3:0] addr_bytes;
  logic [3:0] addr_nibs;
  logic [4:0] dum_left;
  logic [7:0] st1;
  logic [7:0] st2;

  always_comb begin
    n        = r;
    n.sck_q  = sck_s;
    n.cs_q   = cs_s;
    commit   = 1'b0;
    push     = 1'b0;
    rise     = sck_s & ~r.sck_q;
    fall     = ~sck_s & r.sck_q;
    edge_any = rise | fall;
    sdr_byte = four_line_mode_i ? {r.shreg[3:0], io_s} : {r.shreg[6:0], io_s[0]};
    bits_nx  = r.bitcnt + (four_line_mode_i ? 4'h4 : 4'h1);
    addr_bytes = r.wide ? 4'h4 : 4'h3;
    addr_nibs  = r.wide ? 4'h8 : 4'h6;
    dum_left   = {dummy_cycles_i, 1'b0} - r.beat - 5'h01;
    rd_idx     = r.pstart + r.xfer[7:0];
    wr_idx     = r.pstart + r.pcount[7:0];
    st1                = 8'h00;
    st1[ST1_WIP_BIT]   = r.op_in_progress;
    st1[ST1_WEL_BIT]   = r.write_enable_latch;
    st2                = 8'h00;
    st2[ST2_PERR_BIT]  = r.perr;

    if (cs_s) begin
      n.cmd_st = S_IDLE;
      n.io_oe  = 4'h0;
      if (!r.cs_q) begin
        // commit only on a whole byte
        commit = (r.cmd_st == S_DATA) && (r.bitcnt == 4'h0) && (r.pcount != 9'h000);
        // complementary mode nibbles keep the continuous read
        n.cont = ((r.cmd_st == S_RDUM) || (r.cmd_st == S_RDATA)) && r.mode_ok;
      end
    end else if (r.cs_q) begin
      // frame start: continuous read skips the opcode
      n.cmd_st = r.cont ? S_RADDR : S_OPC;
      n.bitcnt = 4'h0;
      n.cnt    = 4'h0;
      // a status poll must not wipe the address that the drain still uses
      n.addr   = (r.pst == P_IDLE) ? 32'h0000_0000 : r.addr;
      n.beat   = 5'h00;
    end else begin
      case (r.cmd_st)
        S_OPC: if (rise) begin
          n.shreg  = sdr_byte;
          n.bitcnt = bits_nx;
          if (bits_nx == 4'h8) begin
            n.bitcnt = 4'h0;
            n.cmd_st = S_IGN;
            case (sdr_byte)
              OPC_WR_EN:    if (!r.op_in_progress) n.write_enable_latch = 1'b1;
              OPC_WR_DIS:   if (!r.op_in_progress) n.write_enable_latch = 1'b0;
              OPC_CLR_STAT: if (!r.op_in_progress) n.perr = 1'b0;
              OPC_RD_ST1, OPC_RD_ST2: begin
                n.cmd_st    = S_STAT;
                n.stat2_sel = (sdr_byte == OPC_RD_ST2);
                n.shreg     = (sdr_byte == OPC_RD_ST2) ? st2 : st1;
              end
              OPC_PAGE_PROG, OPC_PAGE_PROG_4B: if (r.write_enable_latch && !r.op_in_progress) begin
                n.cmd_st = S_ADDR;
                n.wide   = (sdr_byte == OPC_PAGE_PROG_4B) | addr4_mode_i;
                n.pcount = 9'h000;
                n.addr   = 32'h0000_0000;
                n.pbuf   = '1;  // untouched bits stay erased
              end
              // opcode taken the same way as any other
              OPC_DDR_RD, OPC_DDR_RD_4B: if (!r.op_in_progress) begin
                n.cmd_st = S_RADDR;
                n.wide   = (sdr_byte == OPC_DDR_RD_4B) | addr4_mode_i;
                n.addr   = 32'h0000_0000;
              end
              default: n.cmd_st = S_IGN;
            endcase
          end
        end
        // status bytes repeat for as long as the clock runs
        S_STAT: if (fall) begin
          if (four_line_mode_i) begin
            n.io_out = r.shreg[7:4];
            n.io_oe  = 4'hF;
            n.shreg  = {r.shreg[3:0], 4'h0};
          end else begin
            n.io_out = {2'b00, r.shreg[7], 1'b0};
            n.io_oe  = 4'h2;
            n.shreg  = {r.shreg[6:0], 1'b0};
          end
          n.bitcnt = bits_nx;
          if (bits_nx == 4'h8) begin
            n.bitcnt = 4'h0;
            n.shreg  = r.stat2_sel ? st2 : st1;
          end
        end
        S_ADDR: if (rise) begin
          n.shreg  = sdr_byte;
          n.bitcnt = bits_nx;
          if (bits_nx == 4'h8) begin
            n.bitcnt = 4'h0;
            n.addr   = {r.addr[23:0], sdr_byte};
            n.cnt    = r.cnt + 4'h1;
            // any start byte, page base kept aligned
            if (n.cnt == addr_bytes) begin
              n.cmd_st = S_DATA;
              n.pstart = sdr_byte;
            end
          end
        end
        S_DATA: if (rise) begin
          n.shreg  = sdr_byte;
          n.bitcnt = bits_nx;
          if (bits_nx == 4'h8) begin
            n.bitcnt = 4'h0;
            // page buffer, wraps within the page; past a full page bytes land on the start byte
            n.pbuf[wr_idx] = sdr_byte;
            n.pcount = (r.pcount == PAGE_BYTES) ? r.pcount : 9'(r.pcount + 9'h001);
          end
        end
        // address nibbles on both edges
        // the fall that closes the opcode cycle is not an address edge
        S_RADDR: if (rise || (fall && (r.cnt != 4'h0))) begin
          n.addr = {r.addr[27:0], io_s};
          n.cnt  = r.cnt + 4'h1;
          if (n.cnt == addr_nibs) begin
            n.cmd_st = S_RMODE;
            n.cnt    = 4'h0;
          end
        end
        S_RMODE: if (edge_any) begin
          n.shreg = {r.shreg[3:0], io_s};
          n.cnt   = r.cnt + 4'h1;
          if (r.cnt == 4'h1) begin
            n.mode_ok = (r.shreg[3:0] == ~io_s);
            n.rd_addr = r.addr;
            n.beat    = 5'h00;
            n.cmd_st  = (dummy_cycles_i == 4'h0) ? S_RDATA : S_RDUM;
            n.pend    = (dummy_cycles_i == 4'h0);
            // a short dummy phase starts its preamble right here
            if (learning_enable_i && (dummy_cycles_i != 4'h0)
                && ({dummy_cycles_i, 1'b0} <= 5'h08)) begin
              n.io_out = {4{learning_pattern_i[3'({dummy_cycles_i, 1'b0} - 5'h01)]}};
              n.io_oe  = 4'hF;
            end
          end
        end
        S_RDUM: if (edge_any) begin
          n.beat = r.beat + 5'h01;
          if (dum_left == 5'h00) begin
            n.cmd_st = S_RDATA;
            n.pend   = 1'b1;
          // last four cycles carry the preamble
          end else if (learning_enable_i && (dum_left <= 5'h08)) begin
            // same pattern bit on every line
            n.io_out = {4{learning_pattern_i[3'(dum_left - 5'h01)]}};
            n.io_oe  = 4'hF;
          end else begin
            n.io_oe  = 4'h0;
          end
        end
        // data nibbles, the array answers one cycle after the address moves
        S_RDATA: begin
          if (r.pend) begin
            n.io_out = rd_data_i[7:4];
            n.io_oe  = 4'hF;
            n.pend   = 1'b0;
            n.nib    = 1'b0;
          end else if (edge_any) begin
            if (!r.nib) begin
              n.io_out = rd_data_i[3:0];
              n.nib    = 1'b1;
            end else begin
              n.rd_addr = r.rd_addr + 32'h0000_0001;
              n.pend    = 1'b1;
            end
          end
        end
        S_IDLE, S_IGN: n.cmd_st = r.cmd_st;
        default: n.cmd_st = S_IDLE;
      endcase
    end

    // program engine
    case (r.pst)
      P_IDLE: if (commit) begin
        if (region_protected_i) begin
          n.perr = 1'b1;
          n.write_enable_latch  = 1'b0;
        end else begin
          n.op_in_progress  = 1'b1;
          n.xfer = 9'h000;
          n.pst  = P_XFER;
        end
      end
      // the array ANDs, so loaded ones leave cells unchanged
      P_XFER: begin
        push = 1'b1;
        if (fifo_in_ready) begin
          n.xfer = r.xfer + 9'h001;
          if (n.xfer == r.pcount) begin
            n.pst   = P_WAIT;
            n.timer = TW'(PROG_CYCLES);
          end
        end
      end
      // flag drops once the time has run and the array took all
      P_WAIT: begin
        if (r.timer != '0) begin
          n.timer = r.timer - 1'b1;
        end else if (!fifo_out_valid) begin
          n.op_in_progress = 1'b0;
          n.write_enable_latch = 1'b0;
          n.pst = P_IDLE;
        end
      end
      default: n.pst = P_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r        <= '0;
      r.cmd_st <= S_IDLE;
      r.pst    <= P_IDLE;
      r.cs_q   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign io_out_o             = r.io_out;
  assign io_oe_o              = r.io_oe;
  assign op_in_progress_o     = r.op_in_progress;
  assign write_enable_latch_o = r.write_enable_latch;
  assign program_error_o      = r.perr;
  assign prog_valid_o         = fifo_out_valid;
  assign prog_addr_o          = fifo_out_data[39:8];
  assign prog_data_o          = fifo_out_data[7:0];
  assign rd_addr_o            = r.rd_addr;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_wel_before_prog: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(r.op_in_progress) |-> $past(r.write_enable_latch))
    else $error("program started without write enable");

  a_commit_starts: assert property (@(posedge mclk_i) disable iff (rst_i)
    commit && !region_protected_i && (r.pst == P_IDLE) |=> r.op_in_progress && (r.pst == P_XFER))
    else $error("valid commit did not start programming");

  a_commit_byte_edge: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(r.op_in_progress) |-> ($past(r.bitcnt) == 4'h0) && ($past(r.cmd_st) == S_DATA))
    else $error("program committed off a byte boundary");

  a_wip_end_timed: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(r.op_in_progress) |-> ($past(r.timer) == '0) && ($past(r.pst) == P_WAIT))
    else $error("in-progress flag cleared early");

  a_prot_error_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    commit && region_protected_i && (r.pst == P_IDLE) |=> r.perr && !r.op_in_progress)
    else $error("protected program did not flag an error");

  a_page_limit: assert property (@(posedge mclk_i) disable iff (rst_i)
    r.pcount <= PAGE_BYTES)
    else $error("page buffer count above one page");

  a_preamble_same: assert property (@(posedge mclk_i) disable iff (rst_i)
    (r.cmd_st == S_RDUM) && (r.io_oe == 4'hF) |-> (r.io_out == 4'h0) || (r.io_out == 4'hF))
    else $error("preamble differs between lines");

  a_preamble_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    (r.cmd_st == S_RDATA) && ($past(r.cmd_st) == S_RDUM) && learning_enable_i
      && (dummy_cycles_i >= 4'h4) |-> ($past(r.io_oe) == 4'hF))
    else $error("preamble not driven before data");

  a_pp_addr_width: assert property (@(posedge mclk_i) disable iff (rst_i)
    (r.cmd_st == S_DATA) && ($past(r.cmd_st) == S_ADDR) |-> r.cnt == (r.wide ? 4'h4 : 4'h3))
    else $error("wrong program address length");

  a_rd_addr_width: assert property (@(posedge mclk_i) disable iff (rst_i)
    (r.cmd_st == S_RMODE) && ($past(r.cmd_st) == S_RADDR) |-> $past(r.cnt) == (r.wide ? 4'h7 : 4'h5))
    else $error("wrong read address length");

endmodule // sfp_flash_cmd

//--- sfp_host_model.sv
/* Host spi controller model: chip select, mode 0 clock, io drive.
   Assumes the bench pulls released io pins high. */
`timescale 1ns/1ps
module sfp_host_model (
  // clock
  input  wire logic  mclk_i,
  // spi pins
  output logic       sck_o,
  output logic       cs_n_o,
  output logic [3:0] io_o,
  output logic [3:0] io_en_o
);
  // ------------------------------
  // idle pins and bus steps
  // ------------------------------
  initial begin
    sck_o   = 1'b0;
    cs_n_o  = 1'b1;
    io_o    = 4'h0;
    io_en_o = 4'h0;
  end
  // land just after a clock edge
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic rel();
    io_en_o = 4'h0;
  endtask
  task automatic sel(input logic v);
    wt(20);
    cs_n_o = v;
    rel();
    wt(20);
  endtask
  // io moves mid half period, so it never races the sampled edge
  task automatic edg(input logic [3:0] v, input logic [3:0] en);
    wt(10);
    io_o    = v;
    io_en_o = en;
    wt(10);
    sck_o   = ~sck_o;
  endtask
  task automatic nib(input logic [3:0] v, input logic [3:0] en);
    edg(v, en);
    edg(v, en);
  endtask
  task automatic put(input logic [7:0] b, input logic q);
    if (q) begin
      nib(b[7:4], 4'hF);
      nib(b[3:0], 4'hF);
    end else begin
      for (int i = 7; i >= 0; i--) nib({3'h0, b[i]}, 4'h1);
    end
  endtask
endmodule // sfp_host_model

//--- serial_flash_page_program_test.sv
/* Bench for the flash command block: host model on the pins, byte
   array with a stalling program port. Assumes package compiled first. */
`timescale 1ns/1ps
module serial_flash_page_program_test;
  import sfp_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        addr4  = 1'b0;
  logic        quad   = 1'b0;
  logic        prot   = 1'b0;
  logic        rdy    = 1'b0;
  logic        lrn_en = 1'b1;
  logic [3:0]  dum    = 4'h4;
  logic [7:0]  lpat   = 8'h34;
  logic [7:0]  sv;
  logic        sck, cs_n, op_in_progress, write_enable_latch, perr, pvld;
  logic [3:0]  hio, hen, io_out, io_oe, pins;
  logic [7:0]  pdat, rdat;
  logic [31:0] padr, radr;
  logic [7:0]  mem [logic [31:0]];
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #2 mclk_i = ~mclk_i;
  // released lines float high on their pull-ups
  assign pins = (io_oe & io_out) | (~io_oe & hen & hio) | (~io_oe & ~hen);
  sfp_host_model host (.mclk_i(mclk_i), .sck_o(sck), .cs_n_o(cs_n), .io_o(hio), .io_en_o(hen));
  sfp_flash_cmd #(.PAGE_PROG_TIME_NS(20000)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .sck_i(sck), .cs_n_i(cs_n), .io_in_i(pins), .io_out_o(io_out), .io_oe_o(io_oe),
    .addr4_mode_i(addr4), .four_line_mode_i(quad), .learning_enable_i(lrn_en),
    .learning_pattern_i(lpat), .dummy_cycles_i(dum), .region_protected_i(prot),
    .op_in_progress_o(op_in_progress), .write_enable_latch_o(write_enable_latch), .program_error_o(perr),
    .prog_valid_o(pvld), .prog_addr_o(padr), .prog_data_o(pdat), .prog_ready_i(rdy),
    .rd_addr_o(radr), .rd_data_i(rdat));
  function automatic logic [7:0] rdm(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // array keeps old AND new; ready drops two cycles in four to stall
  always @(posedge mclk_i) begin
    if (pvld === 1'b1 && rdy) mem[padr] = rdm(padr) & pdat;
    cyc++;
    #1 rdy = cyc[1];
    rdat = rdm(radr);
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na,
                       input logic [31:0] d, input int nd, input int xb);
    host.sel(1'b0);
    host.put(op, quad);
    for (int i = na - 1; i >= 0; i--) host.put(a[8*i +: 8], quad);
    for (int i = 0; i < nd; i++) host.put(d[31-8*i -: 8], quad);
    for (int i = 0; i < xb; i++) host.nib(4'h0, 4'h1);
    host.sel(1'b1);
  endtask
  task automatic wdone();
    for (int i = 0; i < 8000 && op_in_progress !== 1'b0; i++) host.wt(1);
    if (op_in_progress !== 1'b0) begin
      num_errors++;
      close_out();
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    chk("status", {op_in_progress, write_enable_latch, perr, io_oe}, 7'h00);
    frame(OPC_PAGE_PROG, 32'h1000, 3, 32'h0, 1, 0);
    chk("busy", op_in_progress, 1'b0);
    frame(OPC_WR_EN, 0, 0, 0, 0, 0);
    chk("latch", write_enable_latch, 1'b1);
    mem[32'h1200] = 8'hF0;
    frame(OPC_PAGE_PROG, 32'h12FF, 3, 32'hA53C_0000, 2, 0);
    chk("busy", op_in_progress, 1'b1);
    // busy flag seen through a status read
    host.sel(1'b0);
    host.put(OPC_RD_ST1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      host.wt(8);
      sv[i] = io_out[1];
      host.nib(4'h0, 4'h0);
    end
    chk("status1", {io_oe, sv}, 12'h203);
    host.sel(1'b1);
    wdone();
    chk("byte", rdm(32'h12FF), 8'hA5);
    chk("wrap", rdm(32'h1200), 8'h30);
    chk("latch", write_enable_latch, 1'b0);
    $display("test single line program done");
    quad = 1'b1;
    for (int k = 0; k < 2; k++) begin
      addr4 = k[0];
      frame(OPC_WR_EN, 0, 0, 0, 0, 0);
      frame(k ? OPC_PAGE_PROG : OPC_PAGE_PROG_4B, 32'hAB00_0010 + k, 4, 32'h5A00_0000, 1, 0);
      wdone();
      chk("wide", rdm(32'hAB00_0010 + k), 8'h5A);
    end
    $display("test wide address done");
    quad  = 1'b0;
    addr4 = 1'b0;
    frame(OPC_WR_EN, 0, 0, 0, 0, 0);
    frame(OPC_PAGE_PROG, 32'h2000, 3, 32'h0, 1, 4);
    chk("stray", {op_in_progress, rdm(32'h2000)}, 9'h0FF);
    prot = 1'b1;
    frame(OPC_WR_EN, 0, 0, 0, 0, 0);
    frame(OPC_PAGE_PROG, 32'h3000, 3, 32'h0, 1, 0);
    chk("prot", {perr, op_in_progress, write_enable_latch, rdm(32'h3000)}, 11'h4FF);
    prot = 1'b0;
    $display("test refusals done");
    quad = 1'b1;
    mem[32'h123456] = 8'hC3;
    for (int k = 0; k < 2; k++) begin
      lpat = k[0] ? 8'hA5 : 8'h34;
      host.sel(1'b0);
      host.put(OPC_DDR_RD, 1'b1);
      for (int i = 0; i < 6; i++) host.edg(4'(24'h123456 >> (20 - 4*i)), 4'hF);
      host.nib(4'hF, 4'hF);
      host.rel();
      host.wt(8);
      for (int i = 0; i < 10; i++) begin
        if (i < 8) chk("preamble", {io_oe, io_out}, {4'hF, {4{lpat[7-i]}}});
        else chk("first", {io_oe, io_out}, {4'hF, (i[0] ? 4'h3 : 4'hC)});
        host.edg(4'h0, 4'h0);
        host.wt(8);
      end
      host.sel(1'b1);
    end
    $display("test learning preamble done");
    close_out();
  end
endmodule // serial_flash_page_program_test
